// >>> lad_regs.svh
/*
  Register indices, field positions, reset values and counts for the
  channel alarm status block.
  Assumes: included by the package and the design module by bare name.
*/
`ifndef LAD_REGS_SVH
`define LAD_REGS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define LAD_IDX_CTRL 8'h00
`define LAD_IDX_CHG 8'h02
`define LAD_IDX_ALARM 8'h03

// ==========================================================
// alarm status fields
`define LAD_AS_PRBS 6
`define LAD_AS_DLOS 5
`define LAD_AS_ALOS 4
`define LAD_AS_FL 3
`define LAD_AS_LOL 2
`define LAD_AS_LOS 1
`define LAD_AS_DMO 0

// ==========================================================
// control fields and reset, change register field
`define LAD_CTL_PRBS_EN 0
`define LAD_CTL_E3 1
`define LAD_CTL_RESET 8'h00
`define LAD_CHG_LOS 1

// ==========================================================
// detector counts: zero run and density window in bit periods, density in percent, PRBS thresholds in errors
`define LAD_LOS_ZEROS 160
`define LAD_DENS_WIN 32
`define LAD_DENS_PCT 33
`define LAD_DENS_MIN ((`LAD_DENS_WIN * `LAD_DENS_PCT + 99) / 100)
`define LAD_PRBS_LOSE 32
`define LAD_PRBS_GAIN 1

`endif

// >>> lad_pkg.sv
/*
  Types and address helper for the channel alarm status block.
  Assumes: lad_regs.svh is on the include path.
*/
`include "lad_regs.svh"

package lad_pkg;

  typedef enum logic {LAD_HUNT, LAD_LOCK} lad_lock_t;

  // byte address of a register index
  function automatic logic [7:0] lad_addr(input logic [7:0] idx);
    lad_addr = {idx[5:0], 2'b00};
  endfunction

endpackage

// >>> lad_alarm_status.sv
/*
  Channel alarm status: digital loss-of-signal detector, PRBS lock
  indicator, combined loss-of-signal state and an APB register slave.
  Assumes: one clock edge per received bit; line and alarm inputs are
  synchronous to clock; the analog detector, jitter FIFO, lock and drive
  monitors sit outside and hand in their states as levels.
*/
`timescale 1ns/1ps
`include "lad_regs.svh"

module lad_alarm_status
  import lad_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // receive line, one bit per clock
  input wire logic rx_pulse,
  input wire logic rx_data,
  // states of neighbouring monitors
  input wire logic analog_los,
  input wire logic fl_alarm,
  input wire logic rx_lol,
  input wire logic tx_dmo,
  // combined loss of signal
  output logic los_defect
);

  // ==========================================================
  // state
  logic [7:0] ctrl, next_ctrl;
  logic [7:0] zero_cnt, next_zero_cnt;
  logic [4:0] win_cnt, next_win_cnt;
  logic [5:0] ones_cnt, next_ones_cnt;
  logic dlos, next_dlos;
  logic [14:0] prbs_sh, next_prbs_sh;
  logic [7:0] bit_cnt, next_bit_cnt;
  logic [5:0] err_cnt, next_err_cnt;
  lad_lock_t lock_st, next_lock_st;
  logic los_chg, next_los_chg;
  logic next_los_defect;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;

  logic setup, wr_done, rd_done, prbs_err, prbs_lost;
  logic [5:0] ones_total, err_total;
  logic [7:0] alarm_word;

  assign setup = psel && !penable;
  assign wr_done = psel && penable && pready && pwrite;
  assign rd_done = psel && penable && pready && !pwrite;
  assign prbs_err = rx_data != (prbs_sh[14] ^ prbs_sh[13]);
  assign prbs_lost = lock_st != LAD_LOCK;
  assign ones_total = ones_cnt + {5'h00, rx_pulse};
  // saturate so a long error burst cannot wrap back to a clean count
  assign err_total = (err_cnt == 6'h3F) ? err_cnt : err_cnt + {5'h00, prbs_err};

  always_comb
  begin
    alarm_word = 8'h00;
    alarm_word[`LAD_AS_PRBS] = prbs_lost;
    alarm_word[`LAD_AS_DLOS] = dlos;
    alarm_word[`LAD_AS_ALOS] = analog_los;
    alarm_word[`LAD_AS_FL] = fl_alarm;
    alarm_word[`LAD_AS_LOL] = rx_lol;
    alarm_word[`LAD_AS_LOS] = los_defect;
    alarm_word[`LAD_AS_DMO] = tx_dmo;
  end

  // ==========================================================
  // next values
  always_comb
  begin
    next_ctrl = ctrl;
    next_zero_cnt = zero_cnt;
    next_win_cnt = win_cnt;
    next_ones_cnt = ones_cnt;
    next_dlos = dlos;
    next_prbs_sh = {prbs_sh[13:0], rx_data};
    next_bit_cnt = bit_cnt + 8'h01;
    next_err_cnt = err_total;
    next_lock_st = lock_st;
    next_los_chg = los_chg;
    next_prdata = prdata;
    next_pready = setup;
    next_pslverr = 1'b0;

    // digital detector only runs in DS3/STS-1 operation
    if (ctrl[`LAD_CTL_E3])
    begin
      next_zero_cnt = 8'h00;
      next_win_cnt = 5'h00;
      next_ones_cnt = 6'h00;
      next_dlos = 1'b0;
    end
    else
    begin
      next_zero_cnt = rx_pulse ? 8'h00 : zero_cnt + 8'h01;
      if (!rx_pulse && zero_cnt == 8'(`LAD_LOS_ZEROS - 1))
      begin
        next_dlos = 1'b1;
        next_zero_cnt = 8'(`LAD_LOS_ZEROS - 1);
      end
      next_win_cnt = win_cnt + 5'h01;
      next_ones_cnt = ones_total;
      if (win_cnt == 5'(`LAD_DENS_WIN - 1))
      begin
        next_ones_cnt = 6'h00;
        if (dlos && ones_total >= 6'(`LAD_DENS_MIN))
          next_dlos = 1'b0;
      end
    end

    // checker is self-synchronising, so lock follows the error rate alone
    if (!ctrl[`LAD_CTL_PRBS_EN])
    begin
      next_bit_cnt = 8'h00;
      next_err_cnt = 6'h00;
      next_lock_st = LAD_HUNT;
    end
    else if (bit_cnt == 8'hFF)
    begin
      next_err_cnt = 6'h00;
      if (lock_st == LAD_LOCK && err_total >= 6'(`LAD_PRBS_LOSE))
        next_lock_st = LAD_HUNT;
      else if (lock_st == LAD_HUNT && err_total <= 6'(`LAD_PRBS_GAIN))
        next_lock_st = LAD_LOCK;
    end

    next_los_defect = dlos || analog_los;

    // set wins over the clear-on-read
    if (rd_done && paddr == lad_addr(`LAD_IDX_CHG))
      next_los_chg = 1'b0;
    if (next_los_defect != los_defect)
      next_los_chg = 1'b1;

    if (wr_done && paddr == lad_addr(`LAD_IDX_CTRL))
      next_ctrl = pwdata[7:0];

    // read data and error are captured in the setup cycle
    if (setup)
    begin
      unique case (paddr)
        lad_addr(`LAD_IDX_CTRL): next_prdata = {24'h000000, ctrl};
        lad_addr(`LAD_IDX_CHG): next_prdata = {30'h0000000, los_chg, 1'b0};
        lad_addr(`LAD_IDX_ALARM): next_prdata = {24'h000000, alarm_word};
        default:
        begin
          next_prdata = 32'h00000000;
          next_pslverr = 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= `LAD_CTL_RESET;
      zero_cnt <= 8'h00;
      win_cnt <= 5'h00;
      ones_cnt <= 6'h00;
      dlos <= 1'b0;
      prbs_sh <= 15'h0000;
      bit_cnt <= 8'h00;
      err_cnt <= 6'h00;
      lock_st <= LAD_HUNT;
      los_chg <= 1'b0;
      los_defect <= 1'b0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      zero_cnt <= next_zero_cnt;
      win_cnt <= next_win_cnt;
      ones_cnt <= next_ones_cnt;
      dlos <= next_dlos;
      prbs_sh <= next_prbs_sh;
      bit_cnt <= next_bit_cnt;
      err_cnt <= next_err_cnt;
      lock_st <= next_lock_st;
      los_chg <= next_los_chg;
      los_defect <= next_los_defect;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_alarm_setup;
    psel && !penable && paddr == lad_addr(`LAD_IDX_ALARM);
  endsequence

  chk_prbs_bit: assert property (s_alarm_setup |=> prdata[6] == $past(prbs_lost))
    else $error("prbs lock bit wrong");
  chk_prbs_lose: assert property ($rose(prbs_lost) && $past(ctrl[0])
    |-> $past(bit_cnt) == 8'hFF && $past(err_total) >= 6'd32)
    else $error("lock lost without error burst");
  chk_prbs_gain: assert property ($fell(prbs_lost) |-> $past(err_total) <= 6'd1)
    else $error("lock gained with errors");
  chk_dlos_set: assert property (!ctrl[1] && !rx_pulse && zero_cnt == 8'd159 |=> dlos)
    else $error("digital los not declared");
  chk_dlos_clr: assert property ($fell(dlos) && !$past(ctrl[1])
    |-> $past(ones_total) >= 6'd11 && $past(win_cnt) == 5'd31)
    else $error("digital los cleared too early");
  chk_dlos_bit: assert property (s_alarm_setup |=> prdata[5] == $past(dlos))
    else $error("digital los bit wrong");
  chk_los_or: assert property (##1 los_defect == $past(dlos || analog_los))
    else $error("combined los wrong");
  chk_los_bit: assert property (s_alarm_setup ##1 pready |-> prdata[1] == $past(los_defect))
    else $error("combined los bit wrong");
  chk_alos_bit: assert property (s_alarm_setup |=> prdata[4] == $past(analog_los))
    else $error("analog los bit wrong");
  chk_los_chg: assert property ($changed(los_defect) |-> los_chg)
    else $error("los change not flagged");
  chk_alarm_wr: assert property (wr_done && paddr == lad_addr(`LAD_IDX_ALARM)
    |=> $stable(ctrl) && $stable(los_chg))
    else $error("alarm write had effect");

endmodule

// >>> lad_line_model.sv
/*
  Line source model: one received bit per clock towards the alarm block.
  Assumes: the bench changes mode and flip right after a rising edge.
*/
`timescale 1ns/1ps
module lad_line_model
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // bench control: 0 silent, 1 one in four, 2 one in two, 3 pattern
  input wire logic [1:0] mode,
  input wire logic flip,
  // line bits
  output logic rx_pulse,
  output logic rx_data
);
  // ==========================================================
  // pattern source, looped back to the checker input
  logic [14:0] lfsr;
  logic [1:0] phase;
  logic bit_now;
  always_comb
  begin
    case (mode)
      2'h0: bit_now = 1'b0;
      2'h1: bit_now = (phase == 2'h0);
      2'h2: bit_now = phase[0];
      default: bit_now = lfsr[14] ^ lfsr[13] ^ flip;
    endcase
  end
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lfsr <= 15'h7FFF;
      phase <= 2'h0;
      rx_pulse <= 1'b0;
      rx_data <= 1'b0;
    end
    else
    begin
      lfsr <= {lfsr[13:0], lfsr[14] ^ lfsr[13]};
      phase <= phase + 2'h1;
      rx_pulse <= bit_now;
      rx_data <= bit_now;
    end
  end
endmodule

// >>> tb_line_alarm_status_detect.sv
/*
  Self-checking bench for the channel alarm status block.
  Assumes: zero-wait APB slave; line model drives one bit per clock.
*/
`timescale 1ns/1ps
module tb_line_alarm_status_detect;
  import lad_pkg::*;
  // ==========================================================
  // signals
  logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, rx_pulse, rx_data, los_defect, flip = 1'b0;
  logic analog_los = 1'b0, fl_alarm = 1'b0, rx_lol = 1'b0, tx_dmo = 1'b0;
  logic [1:0] mode = 2'h3;
  logic [31:0] seed = 32'd98;
  int num_errors = 0, num_checks = 0, cycles = 0;
  always #2.5 clock = ~clock;
  lad_alarm_status dut_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_pulse(rx_pulse), .rx_data(rx_data), .analog_los(analog_los),
    .fl_alarm(fl_alarm), .rx_lol(rx_lol), .tx_dmo(tx_dmo), .los_defect(los_defect));
  lad_line_model line_u (.clock(clock), .rst_n(rst_n), .mode(mode), .flip(flip),
    .rx_pulse(rx_pulse), .rx_data(rx_data));
  // ==========================================================
  // helpers
  function automatic logic [31:0] exp_as(input logic lost, input logic dl);
    exp_as = {24'h0, 1'b0, lost, dl, analog_los, fl_alarm, rx_lol, dl | analog_los, tx_dmo};
  endfunction
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xorshift = x ^ (x << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rnd_mon();
    @(posedge clock);
    seed = xorshift(seed);
    {analog_los, fl_alarm, rx_lol, tx_dmo} <= seed[3:0];
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      final_report();
    end
  end
  // ==========================================================
  // scenarios
  initial
  begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rnd_mon();
    apb(1'b0, lad_addr(8'h03), 32'h0);
    chk(rd, exp_as(1'b1, 1'b0));
    chk({31'h0, err}, 32'h0);
    apb(1'b1, lad_addr(8'h00), 32'h1);
    repeat (600) @(posedge clock);
    apb(1'b0, lad_addr(8'h03), 32'h0);
    chk(rd, exp_as(1'b0, 1'b0));
    flip <= 1'b1;
    repeat (300) @(posedge clock);
    apb(1'b0, lad_addr(8'h03), 32'h0);
    chk(rd, exp_as(1'b1, 1'b0));
    apb(1'b1, lad_addr(8'h03), 32'hFF);
    apb(1'b0, lad_addr(8'h03), 32'h0);
    chk(rd, exp_as(1'b1, 1'b0));
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    analog_los <= 1'b0;
    mode <= 2'h2;
    apb(1'b0, lad_addr(8'h02), 32'h0);
    mode <= 2'h0;
    repeat (145) @(posedge clock);
    apb(1'b0, lad_addr(8'h03), 32'h0);
    chk(rd, exp_as(1'b1, 1'b0));
    repeat (20) @(posedge clock);
    apb(1'b0, lad_addr(8'h03), 32'h0);
    chk(rd, exp_as(1'b1, 1'b1));
    chk({31'h0, los_defect}, 32'h1);
    apb(1'b0, lad_addr(8'h02), 32'h0);
    chk(rd & 32'h2, 32'h2);
    apb(1'b0, lad_addr(8'h02), 32'h0);
    chk(rd & 32'h2, 32'h0);
    mode <= 2'h1;
    repeat (100) @(posedge clock);
    apb(1'b0, lad_addr(8'h03), 32'h0);
    chk(rd, exp_as(1'b1, 1'b1));
    mode <= 2'h2;
    repeat (80) @(posedge clock);
    apb(1'b0, lad_addr(8'h03), 32'h0);
    chk(rd, exp_as(1'b1, 1'b0));
    repeat (8)
    begin
      rnd_mon();
      repeat (4) @(posedge clock);
      apb(1'b0, lad_addr(8'h03), 32'h0);
      chk(rd, exp_as(1'b1, 1'b0));
      chk({31'h0, los_defect}, {31'h0, analog_los});
    end
    apb(1'b1, lad_addr(8'h00), 32'h2);
    mode <= 2'h0;
    repeat (200) @(posedge clock);
    apb(1'b0, lad_addr(8'h03), 32'h0);
    chk(rd, exp_as(1'b1, 1'b0));
    final_report();
  end
endmodule
